// [frt_pkg.sv]
package frt_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MATCH_OFS = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	localparam logic [7:0] MASK_OFS = 8'h10;

	// field positions
	localparam int EN_BIT = 0;
	localparam int MODE_BIT = 1;
	localparam int CMP_BIT = 8;
	localparam int OVF_BIT = 9;

	// reset values and writable bits
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MATCH_RST = 32'h0000_0000;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] STAT_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0300;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0303;
	localparam logic [31:0] EVT_MASK = 32'h0000_0300;
	localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	// timing: core clock period and interrupt latency bound
	localparam int CLK_PERIOD_PS = 8000;
	localparam int IRQ_LAT_PS = 16000;
	localparam int IRQ_LAT_CYC = IRQ_LAT_PS / CLK_PERIOD_PS;

	typedef enum logic {FRT_MODE_FREE, FRT_MODE_MATCH} frt_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wrData;
		logic wrStb;
		logic rdStb;
	} frt_bus_req_t;

	typedef struct packed {
		logic [31:0] ctrlReg;
		logic [31:0] matchReg;
		logic [31:0] countReg;
		logic [31:0] statReg;
		logic [31:0] maskReg;
		logic [31:0] rdDataReg;
		logic irqReg;
		logic wakeReg;
		logic [2:0] syncReg;
		logic tmrLvlReg;
	} frt_state_t;

	localparam frt_state_t ST_RST = '{
		ctrlReg: CTRL_RST,
		matchReg: MATCH_RST,
		countReg: COUNT_RST,
		statReg: STAT_RST,
		maskReg: MASK_RST,
		rdDataReg: ZERO32,
		irqReg: 1'b0,
		wakeReg: 1'b0,
		syncReg: 3'h0,
		tmrLvlReg: 1'b0
	};
endpackage

// [frt_timer.sv]
`timescale 1ns/100ps
module frt_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire frt_pkg::frt_bus_req_t busReq,
	output logic [31:0] rdData,
	// timer clock pin
	input wire logic tmrClkPin,
	// events
	output logic irq,
	output logic wakeUp
);
	import frt_pkg::*;

	localparam int IRQ_LAT = IRQ_LAT_CYC;

	frt_state_t st_reg;
	frt_state_t st_next;

	logic tick;
	logic enabled;
	frt_mode_t mode;
	logic countWr;
	logic evtCmp;
	logic evtOvf;
	logic [31:0] setBits;
	logic [31:0] clrBits;
	logic [31:0] gateBits;

	function automatic logic frt_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	always_comb begin
		st_next = st_reg;
		// timer clock pin: three stages, level accepted once stages two and three agree
		st_next.syncReg = {st_reg.syncReg[1:0], tmrClkPin};
		tick = 1'b0;
		if (st_reg.syncReg[1] == st_reg.syncReg[2]) begin
			st_next.tmrLvlReg = st_reg.syncReg[2];
			tick = st_reg.syncReg[2] & ~st_reg.tmrLvlReg;
		end
		enabled = st_reg.ctrlReg[EN_BIT];
		mode = st_reg.ctrlReg[MODE_BIT] ? FRT_MODE_MATCH : FRT_MODE_FREE;
		countWr = busReq.wrStb && frt_hit(busReq.addr, COUNT_OFS);
		evtCmp = 1'b0;
		evtOvf = 1'b0;

		// counting never looks at any sleep state
		if (countWr && enabled) begin
			st_next.countReg = ZERO32;
		end else if (enabled && tick) begin
			if (mode == FRT_MODE_MATCH && st_reg.countReg == st_reg.matchReg) begin
				st_next.countReg = ZERO32;
			end else begin
				st_next.countReg = st_reg.countReg + 32'h0000_0001;
			end
			evtCmp = (mode == FRT_MODE_MATCH) && (st_next.countReg == st_reg.matchReg);
			evtOvf = st_next.countReg == ALL_ONES;
		end

		// register writes
		if (busReq.wrStb) begin
			if (frt_hit(busReq.addr, CTRL_OFS)) begin
				st_next.ctrlReg = busReq.wrData & CTRL_WMASK;
			end
			if (frt_hit(busReq.addr, MATCH_OFS)) begin
				st_next.matchReg = busReq.wrData;
			end
			if (frt_hit(busReq.addr, MASK_OFS)) begin
				st_next.maskReg = busReq.wrData & EVT_MASK;
			end
		end

		// sticky flags, a set in the clearing cycle wins
		setBits = ZERO32;
		setBits[CMP_BIT] = evtCmp;
		setBits[OVF_BIT] = evtOvf;
		clrBits = ZERO32;
		if (busReq.wrStb && frt_hit(busReq.addr, STAT_OFS)) begin
			clrBits = busReq.wrData & EVT_MASK;
		end
		st_next.statReg = (st_reg.statReg & ~clrBits) | setBits;

		// mode picks which enable gates the interrupt
		gateBits = ZERO32;
		if (st_next.ctrlReg[MODE_BIT]) begin
			gateBits[CMP_BIT] = st_next.ctrlReg[CMP_BIT];
		end else begin
			gateBits[OVF_BIT] = st_next.ctrlReg[OVF_BIT];
		end
		st_next.irqReg = |(st_next.statReg & st_next.maskReg & gateBits);
		st_next.wakeReg = evtCmp;

		// read data stands one cycle after the strobe
		st_next.rdDataReg = ZERO32;
		if (busReq.rdStb) begin
			unique case (busReq.addr)
				CTRL_OFS: st_next.rdDataReg = st_reg.ctrlReg;
				MATCH_OFS: st_next.rdDataReg = st_reg.matchReg;
				COUNT_OFS: st_next.rdDataReg = enabled ? st_reg.countReg : ZERO32;
				STAT_OFS: st_next.rdDataReg = st_reg.statReg;
				MASK_OFS: st_next.rdDataReg = st_reg.maskReg;
				default: st_next.rdDataReg = ZERO32;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdData = st_reg.rdDataReg;
	assign irq = st_reg.irqReg;
	assign wakeUp = st_reg.wakeReg;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence cmpEvent;
		evtCmp;
	endsequence

	sequence wakePulse;
		wakeUp ##1 !wakeUp;
	endsequence

	count_hold_a: assert property (!enabled |=> $stable(st_reg.countReg))
		else $error("counter moved while disabled");

	count_step_a: assert property (enabled && tick && !countWr && mode == FRT_MODE_FREE
		|=> st_reg.countReg == $past(st_reg.countReg) + 32'h0000_0001)
		else $error("counter did not step by one");

	free_wrap_a: assert property (enabled && tick && !countWr && mode == FRT_MODE_FREE
		&& st_reg.countReg == ALL_ONES |=> st_reg.countReg == ZERO32)
		else $error("counter did not wrap to zero");

	match_restart_a: assert property (enabled && tick && !countWr && mode == FRT_MODE_MATCH
		&& st_reg.countReg == st_reg.matchReg |=> st_reg.countReg == ZERO32)
		else $error("counter did not restart after match");

	ovf_flag_a: assert property (enabled && tick && !countWr
		&& st_reg.countReg == 32'hFFFF_FFFE |=> st_reg.statReg[OVF_BIT])
		else $error("overflow flag missing at all ones");

	match_wake_a: assert property (cmpEvent |=> wakePulse)
		else $error("wake-up pulse missing after match");

	wake_match_a: assert property ($rose(wakeUp) |-> st_reg.statReg[CMP_BIT]
		&& st_reg.countReg == st_reg.matchReg)
		else $error("wake-up without match");

	irq_latency_a: assert property (cmpEvent ##0 (st_next.ctrlReg[CMP_BIT]
		&& st_next.ctrlReg[MODE_BIT] && st_next.maskReg[CMP_BIT])
		|-> ##[1:IRQ_LAT] irq)
		else $error("interrupt late after match");

	free_gate_a: assert property (!st_reg.ctrlReg[MODE_BIT] && !st_reg.ctrlReg[OVF_BIT]
		|-> !irq)
		else $error("free-run interrupt without overflow enable");

	match_gate_a: assert property (st_reg.ctrlReg[MODE_BIT] && !st_reg.ctrlReg[CMP_BIT]
		|-> !irq)
		else $error("match interrupt without match enable");

	flag_clear_a: assert property (busReq.wrStb && frt_hit(busReq.addr, STAT_OFS)
		&& busReq.wrData[CMP_BIT] && !evtCmp |=> !st_reg.statReg[CMP_BIT])
		else $error("match flag not cleared by write of one");

	count_read_a: assert property (busReq.rdStb && frt_hit(busReq.addr, COUNT_OFS) && !enabled
		|=> rdData == ZERO32)
		else $error("counter readable while disabled");

	count_clear_a: assert property (busReq.wrStb && frt_hit(busReq.addr, COUNT_OFS) && enabled
		|=> st_reg.countReg == ZERO32)
		else $error("counter write did not clear the count");

	wake_mode_a: assert property (wakeUp |-> $past(st_reg.ctrlReg[MODE_BIT]))
		else $error("wake-up outside match mode");

	stat_rsvd_a: assert property ((st_reg.statReg & ~EVT_MASK) == ZERO32)
		else $error("reserved status bit set");

	ctrl_rsvd_a: assert property ((st_reg.ctrlReg & ~CTRL_WMASK) == ZERO32)
		else $error("reserved control bit set");
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	import frt_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	frt_bus_req_t busReq = '0;
	logic tmrClkPin = 1'b0;
	logic [31:0] rdData;
	logic irq;
	logic wakeUp;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int wakeCnt = 0;
	int w0;

	frt_timer u_dut (
		.core_clk(core_clk),
		.reset(reset),
		.busReq(busReq),
		.rdData(rdData),
		.tmrClkPin(tmrClkPin),
		.irq(irq),
		.wakeUp(wakeUp)
	);

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (wakeUp === 1'b1) wakeCnt++;
		if (cycles == 5000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
		@(posedge core_clk);
		busReq.wrStb <= 1'b0;
		// let the write settle so a following check sees its effect
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		busReq <= '{addr: a, wrData: 32'h0, wrStb: 1'b0, rdStb: 1'b1};
		@(posedge core_clk);
		busReq.rdStb <= 1'b0;
		#1 chk(rdData, exp);
	endtask

	// one timer tick: pin high and low well beyond the sync depth
	task automatic tick();
		@(posedge core_clk);
		tmrClkPin <= 1'b1;
		repeat (5) @(posedge core_clk);
		tmrClkPin <= 1'b0;
		repeat (5) @(posedge core_clk);
	endtask

	task automatic t_reset_map();
		rd(CTRL_OFS, 32'h0);
		rd(MATCH_OFS, 32'h0);
		rd(COUNT_OFS, 32'h0);
		rd(STAT_OFS, 32'h0);
		rd(MASK_OFS, 32'h0000_0300);
		rd(8'h14, 32'h0);
		wr(CTRL_OFS, 32'hFFFF_FFFF);
		rd(CTRL_OFS, 32'h0000_0303);
		wr(CTRL_OFS, 32'h0);
	endtask

	task automatic t_match();
		wr(MATCH_OFS, 32'h2);
		wr(CTRL_OFS, 32'h0000_0103);
		wr(COUNT_OFS, 32'h0);
		w0 = wakeCnt;
		tick();
		rd(COUNT_OFS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		tick();
		chk({31'h0, irq}, 32'h1);
		chk(wakeCnt - w0, 32'h1);
		rd(STAT_OFS, 32'h0000_0100);
		tick();
		rd(COUNT_OFS, 32'h0);
		wr(MASK_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(MASK_OFS, 32'h0000_0300);
		chk({31'h0, irq}, 32'h1);
		wr(STAT_OFS, 32'h0000_0100);
		rd(STAT_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk(wakeCnt - w0, 32'h1);
	endtask

	task automatic t_gating();
		// match mode with only overflow enable: flag but no interrupt
		wr(CTRL_OFS, 32'h0000_0203);
		wr(COUNT_OFS, 32'h0);
		repeat (2) tick();
		rd(STAT_OFS, 32'h0000_0100);
		chk({31'h0, irq}, 32'h0);
		wr(STAT_OFS, 32'h0000_0300);
		// free mode with only match enable: no interrupt, no restart
		wr(CTRL_OFS, 32'h0000_0101);
		wr(COUNT_OFS, 32'h0);
		repeat (3) tick();
		chk({31'h0, irq}, 32'h0);
		rd(COUNT_OFS, 32'h3);
	endtask

	task automatic t_enable();
		wr(CTRL_OFS, 32'h0);
		repeat (2) tick();
		rd(COUNT_OFS, 32'h0);
		wr(CTRL_OFS, 32'h0000_0001);
		rd(COUNT_OFS, 32'h3);
		wr(COUNT_OFS, 32'h0);
		rd(COUNT_OFS, 32'h0);
		tick();
		rd(COUNT_OFS, 32'h1);
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		t_reset_map();
		t_match();
		t_gating();
		t_enable();
		summarize();
	end
endmodule
